// [src/trim_store_defines.svh]
// Offsets, field positions and defaults of the factory trim word store
`ifndef TRIM_STORE_DEFINES_SVH
`define TRIM_STORE_DEFINES_SVH

`define TRIM_WORD_W          14
`define TRIM_IDX_NINE        16'h2088
`define TRIM_IDX_TEN         16'h2089
`define TRIM_IDX_ELEVEN      16'h208a
`define TRIM_IDX_TWELVE      16'h208b
`define TRIM_IDX_BASE        16'h2088
`define TRIM_ADDR_BASE       18'h08220
`define TRIM_ADDR_MASK       18'h3fff0
`define TRIM_NINE_MASK       14'h1f0f
`define TRIM_TEN_MASK        14'h1f1f
`define TRIM_ELEVEN_MASK     14'h0fff
`define TRIM_TWELVE_MASK     14'h007f
`define TRIM_NINE_DEFAULT    14'h1f0f
`define TRIM_TEN_DEFAULT     14'h1f1f
`define TRIM_ELEVEN_DEFAULT  14'h0f00
`define TRIM_TWELVE_DEFAULT  14'h0040
`define AXI_RESP_OKAY        2'h0
`define AXI_RESP_SLVERR      2'h2

`endif

// [src/trim_store_pkg.sv]
// Types of the factory trim word store
package trim_store_pkg;
   typedef enum logic [1:0] {
      RD_IDLE = 2'b00,
      RD_RESP = 2'b01
   } rd_state_e;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b00,
      WR_RESP = 2'b01
   } wr_state_e;

   typedef logic [13:0] trim_word_t;

   typedef struct packed {
      rd_state_e  rd_state;
      logic       arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      wr_state_e  wr_state;
      logic       aw_seen;
      logic       w_seen;
      logic       aw_hit;
      logic [1:0] bresp;
   } state_s;
endpackage

// [src/factory_trim_word_store.sv]
// Read-only store of four factory trim words behind an AXI4-Lite slave
//
// Contract
// - Word nine at 2088h: output span trim 12..8, gain trim 3..0.
// - Word ten at 2089h: second span trim 12..8, main span 4..0.
// - Word eleven at 208Ah: supply trim 11..8, buffer offset 7..0.
// - Buffer offset is two's complement millivolts, 80h min, 7Fh max.
// - Word twelve at 208Bh: current amp offset trim in bits 6..0.
// - Word nine bit 13 and bits 7..4 read as zero.
// - Word ten bits 7..5 and word twelve bits 13..7 read zero.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "trim_store_defines.svh"

module factory_trim_word_store
   import trim_store_pkg::*;
#(
   parameter trim_word_t NINE_VALUE   = `TRIM_NINE_DEFAULT,
   parameter trim_word_t TEN_VALUE    = `TRIM_TEN_DEFAULT,
   parameter trim_word_t ELEVEN_VALUE = `TRIM_ELEVEN_DEFAULT,
   parameter trim_word_t TWELVE_VALUE = `TRIM_TWELVE_DEFAULT
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,
   input  wire logic        clk_en_i,
   input  wire logic [17:0] s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   input  wire logic [17:0] s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   output logic [4:0]       out_ref_span_trim_o,
   output logic [3:0]       sense_amp_gain_trim_o,
   output logic [4:0]       second_ref_span_trim_o,
   output logic [4:0]       main_ref_span_trim_o,
   output logic [3:0]       analog_supply_ldo_trim_o,
   output logic [7:0]       test_buffer_offset_o,
   output logic [6:0]       current_err_amp_offset_trim_o
);

   // Unimplemented bits are forced to zero whatever the programmed value
   localparam trim_word_t NINE_W   = NINE_VALUE & `TRIM_NINE_MASK;
   localparam trim_word_t TEN_W    = TEN_VALUE & `TRIM_TEN_MASK;
   localparam trim_word_t ELEVEN_W = ELEVEN_VALUE & `TRIM_ELEVEN_MASK;
   localparam trim_word_t TWELVE_W = TWELVE_VALUE & `TRIM_TWELVE_MASK;

   state_s state_ff;
   state_s nxt_state;

   // True when a word-aligned byte address falls inside the four-word trim window
   function automatic logic in_window(input logic [17:0] addr);
      in_window = ((addr & `TRIM_ADDR_MASK) == `TRIM_ADDR_BASE)
                  && (addr[1:0] == 2'h0);
   endfunction

   // Word index 2088h..208Bh taken from a byte address
   function automatic logic [15:0] word_index(input logic [17:0] addr);
      word_index = addr[17:2];
   endfunction

   function automatic trim_word_t lookup(input logic [15:0] idx);
      case (idx)
         `TRIM_IDX_NINE:   lookup = NINE_W;
         `TRIM_IDX_TEN:    lookup = TEN_W;
         `TRIM_IDX_ELEVEN: lookup = ELEVEN_W;
         `TRIM_IDX_TWELVE: lookup = TWELVE_W;
         default:          lookup = 14'h0000;
      endcase
   endfunction

   // Field outputs: the buffer offset is passed on as signed millivolts
   assign out_ref_span_trim_o           = NINE_W[12:8];
   assign sense_amp_gain_trim_o         = NINE_W[3:0];
   assign second_ref_span_trim_o        = TEN_W[12:8];
   assign main_ref_span_trim_o          = TEN_W[4:0];
   assign analog_supply_ldo_trim_o      = ELEVEN_W[11:8];
   assign test_buffer_offset_o          = ELEVEN_W[7:0];
   assign current_err_amp_offset_trim_o = TWELVE_W[6:0];

   logic aw_take;
   logic w_take;
   assign aw_take = s_axi_awvalid_i && s_axi_awready_o;
   assign w_take  = s_axi_wvalid_i && s_axi_wready_o;

   // Readies drop while frozen so that no AW, W or AR handshake is seen but not taken
   assign s_axi_awready_o = clk_en_i && !state_ff.aw_seen
                            && (state_ff.wr_state == WR_IDLE);
   assign s_axi_wready_o  = clk_en_i && !state_ff.w_seen
                            && (state_ff.wr_state == WR_IDLE);
   assign s_axi_bvalid_o  = (state_ff.wr_state == WR_RESP);
   assign s_axi_bresp_o   = state_ff.bresp;
   assign s_axi_arready_o = clk_en_i && state_ff.arready;
   assign s_axi_rvalid_o  = (state_ff.rd_state == RD_RESP);
   assign s_axi_rdata_o   = state_ff.rdata;
   assign s_axi_rresp_o   = state_ff.rresp;

   always_comb begin
      nxt_state = state_ff;
      // Read channel: one-cycle accept, data registered
      case (state_ff.rd_state)
         RD_IDLE: begin
            nxt_state.arready = 1'b1;
            if (s_axi_arvalid_i && state_ff.arready) begin
               nxt_state.arready  = 1'b0;
               nxt_state.rd_state = RD_RESP;
               // Refused reads return zero data
               nxt_state.rdata    = in_window(s_axi_araddr_i) ?
                  {18'h00000, lookup(word_index(s_axi_araddr_i))} :
                  32'h00000000;
               nxt_state.rresp    = in_window(s_axi_araddr_i) ?
                  `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end
         end
         RD_RESP: begin
            nxt_state.arready = 1'b0;
            if (s_axi_rready_i) begin
               nxt_state.rd_state = RD_IDLE;
            end
         end
         default: begin
            nxt_state.rd_state = RD_IDLE;
            nxt_state.arready  = 1'b0;
         end
      endcase
      // Write channel: address and data in either order, never stored
      case (state_ff.wr_state)
         WR_IDLE: begin
            if (aw_take) begin
               nxt_state.aw_seen = 1'b1;
               nxt_state.aw_hit  = in_window(s_axi_awaddr_i);
            end
            if (w_take) begin
               nxt_state.w_seen = 1'b1;
            end
            if ((state_ff.aw_seen || aw_take)
                && (state_ff.w_seen || w_take)) begin
               nxt_state.wr_state = WR_RESP;
               nxt_state.aw_seen  = 1'b0;
               nxt_state.w_seen   = 1'b0;
               // Read-only store: every write is refused, contents kept
               nxt_state.bresp    = `AXI_RESP_SLVERR;
            end
         end
         WR_RESP: begin
            if (s_axi_bready_i) begin
               nxt_state.wr_state = WR_IDLE;
            end
         end
         default: begin
            nxt_state.wr_state = WR_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_ff <= '0;
      end else if (clk_en_i) begin
         state_ff <= nxt_state;
      end
   end

endmodule
`default_nettype wire

// [test/trim_store_assertions.sv]
// Port-level checks for the factory trim word store
`timescale 1ns/1ps
`default_nettype none
module trim_store_checker
   import trim_store_pkg::*;
#(
   parameter trim_word_t NINE_VALUE   = 14'h0,
   parameter trim_word_t TEN_VALUE    = 14'h0,
   parameter trim_word_t ELEVEN_VALUE = 14'h0,
   parameter trim_word_t TWELVE_VALUE = 14'h0
) (
   input wire logic        sys_clk_i,
   input wire logic        reset_i,
   input wire logic        clk_en_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic [4:0]  out_ref_span_trim_o,
   input wire logic [3:0]  sense_amp_gain_trim_o,
   input wire logic [4:0]  second_ref_span_trim_o,
   input wire logic [4:0]  main_ref_span_trim_o,
   input wire logic [3:0]  analog_supply_ldo_trim_o,
   input wire logic [7:0]  test_buffer_offset_o,
   input wire logic [6:0]  current_err_amp_offset_trim_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);
   a_rd_answer: assert property (
      s_axi_arvalid_i && s_axi_arready_o && clk_en_i |=> s_axi_rvalid_o)
      else $error("read not answered");
   a_rd_done: assert property (
      s_axi_rvalid_o && s_axi_rready_i && clk_en_i
      |=> !s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read response not retired");
   a_ar_blocked: assert property (
      s_axi_rvalid_o |-> !s_axi_arready_o) else $error("read overlap");
   a_rd_upper: assert property (
      s_axi_rvalid_o |-> s_axi_rdata_o[31:14] == 18'h0)
      else $error("upper read bits set");
   a_wr_refused: assert property (
      s_axi_bvalid_o |-> s_axi_bresp_o == 2'h2)
      else $error("write not refused");
   a_b_done: assert property (
      s_axi_bvalid_o && s_axi_bready_i && clk_en_i |=> !s_axi_bvalid_o)
      else $error("write response not retired");
   a_nine_fields: assert property (
      {out_ref_span_trim_o, sense_amp_gain_trim_o}
      == {NINE_VALUE[12:8], NINE_VALUE[3:0]}) else $error("word nine");
   a_ten_fields: assert property (
      {second_ref_span_trim_o, main_ref_span_trim_o}
      == {TEN_VALUE[12:8], TEN_VALUE[4:0]}) else $error("word ten");
   a_eleven_fields: assert property (
      {analog_supply_ldo_trim_o, test_buffer_offset_o}
      == ELEVEN_VALUE[11:0]) else $error("word eleven");
   a_twelve_fields: assert property (
      current_err_amp_offset_trim_o == TWELVE_VALUE[6:0])
      else $error("word twelve");
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Bench for the factory trim word store over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import trim_store_pkg::*;
   localparam trim_word_t W9  = 14'h2a5c;
   localparam trim_word_t W10 = 14'h3ff5;
   localparam trim_word_t W11 = 14'h2a80;
   localparam trim_word_t W12 = 14'h3fd3;
   logic        clk, rst, aw_vld, w_vld, b_rdy, ar_vld, r_rdy;
   logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
   logic [17:0] aw_addr, ar_addr;
   logic [31:0] r_data, d;
   logic [1:0]  b_resp, r_resp, r;
   logic [4:0]  f_out, f_sec, f_main;
   logic [3:0]  f_gain, f_ldo;
   logic [7:0]  f_buf;
   logic [6:0]  f_cea;
   logic [13:0] exp [4] = '{W9 & 14'h1f0f, W10 & 14'h1f1f,
                            W11 & 14'h0fff, W12 & 14'h007f};
   logic [17:0] bad [3] = '{18'h08230, 18'h08221, 18'h0821c};
   int          failures, num_checks;
   factory_trim_word_store #(.NINE_VALUE(W9), .TEN_VALUE(W10),
      .ELEVEN_VALUE(W11), .TWELVE_VALUE(W12)) u_factory_trim_word_store (
      .sys_clk_i(clk), .reset_i(rst), .clk_en_i(1'b1),
      .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_vld),
      .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(32'hffffffff),
      .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(w_vld), .s_axi_wready_o(w_rdy),
      .s_axi_bresp_o(b_resp), .s_axi_bvalid_o(b_vld), .s_axi_bready_i(b_rdy),
      .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_vld),
      .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(r_data),
      .s_axi_rresp_o(r_resp), .s_axi_rvalid_o(r_vld), .s_axi_rready_i(r_rdy),
      .out_ref_span_trim_o(f_out), .sense_amp_gain_trim_o(f_gain),
      .second_ref_span_trim_o(f_sec), .main_ref_span_trim_o(f_main),
      .analog_supply_ldo_trim_o(f_ldo), .test_buffer_offset_o(f_buf),
      .current_err_amp_offset_trim_o(f_cea));
   task automatic chk(input string nm, input logic [31:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tick(inout int n);
      @(posedge clk);
      n++;
   endtask
   task automatic limit(input int n);
      if (n >= 50) begin
         failures++;
         final_report();
      end
   endtask
   task automatic rd(input logic [17:0] a);
      int n = 0;
      ar_addr <= a;
      ar_vld <= 1'b1;
      do tick(n); while (ar_rdy !== 1'b1 && n < 50);
      ar_vld <= 1'b0;
      do tick(n); while (r_vld !== 1'b1 && n < 50);
      d = r_data;
      r = r_resp;
      limit(n);
   endtask
   task automatic wr(input logic [17:0] a);
      int   n = 0;
      logic ta = 1'b0;
      logic tw = 1'b0;
      aw_addr <= a;
      aw_vld <= 1'b1;
      w_vld <= 1'b1;
      do begin
         tick(n);
         ta |= (aw_rdy === 1'b1);
         tw |= (w_rdy === 1'b1);
         if (ta) aw_vld <= 1'b0;
         if (tw) w_vld <= 1'b0;
      end while (!(ta && tw) && n < 50);
      do tick(n); while (b_vld !== 1'b1 && n < 50);
      r = b_resp;
      limit(n);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      {rst, r_rdy, b_rdy} = 3'b111;
      {aw_vld, w_vld, ar_vld, aw_addr, ar_addr} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         rd(18'h08220 + 18'(4 * i));
         chk("trim word", d, {18'h0, exp[i]});
         chk("read resp", {30'h0, r}, 32'h0);
      end
      $display("test word reads done");
      chk("nine ten fields", {13'h0, f_out, f_gain, f_sec, f_main},
         {13'h0, W9[12:8], W9[3:0], W10[12:8], W10[4:0]});
      chk("eleven twelve fields", {13'h0, f_ldo, f_buf, f_cea},
         {13'h0, W11[11:8], W11[7:0], W12[6:0]});
      chk("buffer offset", 32'(signed'(f_buf)), 32'hffffff80);
      $display("test field outputs done");
      foreach (bad[i]) begin
         rd(bad[i]);
         chk("unmapped data", d, 32'h0);
         chk("unmapped resp", {30'h0, r}, 32'h2);
      end
      $display("test unmapped reads done");
      for (int i = 0; i < 4; i++) begin
         wr(18'h08220 + 18'(4 * i));
         chk("write resp", {30'h0, r}, 32'h2);
         rd(18'h08220 + 18'(4 * i));
         chk("word after write", d, {18'h0, exp[i]});
      end
      $display("test writes done");
      final_report();
   end
endmodule
bind factory_trim_word_store trim_store_checker #(.NINE_VALUE(NINE_VALUE),
   .TEN_VALUE(TEN_VALUE), .ELEVEN_VALUE(ELEVEN_VALUE),
   .TWELVE_VALUE(TWELVE_VALUE)) u_trim_store_checker (.*);
`default_nettype wire
